// [hw/pll_ctl_regs.svh]
// register offsets, field positions, reset values and timing counts of the synthesizer control
// assumes inclusion by every design file that decodes the register port
`ifndef PLL_CTL_REGS_SVH
`define PLL_CTL_REGS_SVH

`define ADDR_CONTROL        4'h0
`define ADDR_RF_CP          4'h1
`define ADDR_REF_DIV        4'h2
`define ADDR_TIMEOUT        4'h3
`define ADDR_LOCK_STATUS    4'h4
`define ADDR_IRQ_STATUS     4'h5
`define ADDR_IRQ_CLEAR      4'h6
`define ADDR_IRQ_ENABLE     4'h7

`define CTL_REF_OE          0
`define CTL_QUARTER         1
`define CTL_RF_PD           2
`define CTL_IF_PD           3
`define CTL_SLIP_LO         4
`define CTL_SLIP_HI         5
`define CTL_BOOST_EN        6
`define CTL_MUX_LO          8
`define CTL_MUX_HI          11

`define CP_STEADY_LO        0
`define CP_STEADY_HI        3
`define CP_FAST_LO          4
`define CP_FAST_HI          7

`define CONTROL_RESET       16'h0000
`define RF_CP_RESET         16'h00F0
`define REF_DIV_RESET       16'h000A
`define TIMEOUT_RESET       16'h0040

`define LOCK_QUAL_CYCLES    3'h5
`define QUARTER_DIV         2'h3
`define RF_ACQ_NS           10
`define RF_REL_NS           20
`define IF_ACQ_NS           15
`define IF_REL_NS           30
`define CLK_NS              4

`endif

// [hw/pll_ctl_pkg.sv]
// types shared by the synthesizer control block
// assumes nothing beyond a SystemVerilog compiler
package pll_ctl_pkg;
   typedef enum logic [3:0] {
      MUX_TRISTATE  = 4'h0,
      MUX_RF_LOCK   = 4'h1,
      MUX_IF_LOCK   = 4'h2,
      MUX_BOTH_LOCK = 4'h3,
      MUX_REF_DIV   = 4'h4
   } test_pin_selector_t;

   typedef enum logic [1:0] {
      SLIP_OFF = 2'h0,
      SLIP_HALF = 2'h1,
      SLIP_QUARTER = 2'h2,
      SLIP_SIXTEENTH = 2'h3
   } cycle_slip_reduction_t;

   typedef enum logic [2:0] {
      ACQ_IDLE   = 3'b001,
      ACQ_ENGAGE = 3'b010,
      ACQ_STEADY = 3'b100
   } acq_state_t;
endpackage : pll_ctl_pkg

// [hw/lock_detector.sv]
// digital lock detector for one loop with acquire/release hysteresis
// assumes phase error arrives as a clock-cycle count once per qualified comparison event
`include "pll_ctl_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module lock_detector #(
   parameter int ACQ_CYCLES = 3,
   parameter int REL_CYCLES = 5
) (
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic       powered_down,
   input  wire logic       sample,
   input  wire logic [7:0] phase_err,
   output logic            locked
);
   initial begin
      if (ACQ_CYCLES < 1 || REL_CYCLES < ACQ_CYCLES || REL_CYCLES > 255)
         $error("lock_detector thresholds out of range");
   end

   logic [2:0] qual;
   logic [2:0] next_qual;
   logic       next_locked;

   always_comb begin
      next_qual   = qual;
      next_locked = locked;
      if (powered_down) begin
         next_qual   = 3'h0;
         next_locked = 1'b0;
      end else if (sample) begin
         if (locked) begin
            if (phase_err > 8'(REL_CYCLES)) begin
               next_locked = 1'b0;
               next_qual   = 3'h0;
            end
         end else if (phase_err < 8'(ACQ_CYCLES)) begin
            if (qual == `LOCK_QUAL_CYCLES - 3'h1) begin
               next_locked = 1'b1;
               next_qual   = 3'h0;
            end else begin
               next_qual = qual + 3'h1;
            end
         end else begin
            next_qual = 3'h0;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         qual   <= 3'h0;
         locked <= 1'b0;
      end else begin
         qual   <= next_qual;
         locked <= next_locked;
      end
   end
endmodule : lock_detector
`default_nettype wire

// [hw/pll_lock_detect_control.sv]
// control side of a dual synthesizer: reference buffer, reference divider, charge pump gain,
// acquisition timeout with cycle slip reduction or bandwidth boost, and lock detection
// assumes ref_edge pulses once per reference cycle and phase errors are counts of sys_clk cycles
`include "pll_ctl_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module pll_lock_detect_control #(
   parameter int CLK_NS = `CLK_NS
) (
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic [3:0]  addr,
   input  wire logic [15:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [15:0] rdata,
   input  wire logic        ref_edge,
   input  wire logic        ref_output_force_pin,
   input  wire logic [7:0]  rf_phase_err,
   input  wire logic [7:0]  if_phase_err,
   output logic             ref_buffer_output_enable,
   output logic             comparison_edge,
   output logic      [3:0]  rf_cp_gain,
   output logic             fastlock_switch,
   output logic             test_lock_output_pin,
   output logic             irq
);
   // least time rounds up for acquire, longest rounds down for release
   localparam int RF_ACQ = (`RF_ACQ_NS + CLK_NS - 1) / CLK_NS;
   localparam int RF_REL = `RF_REL_NS / CLK_NS;
   localparam int IF_ACQ = (`IF_ACQ_NS + CLK_NS - 1) / CLK_NS;
   localparam int IF_REL = `IF_REL_NS / CLK_NS;

   initial begin
      if (CLK_NS < 1 || CLK_NS > `RF_ACQ_NS)
         $error("clock period unsuitable for lock thresholds");
   end

   function automatic logic [15:0] slip_mask(input logic [1:0] f);
      case (f)
         2'h1:    slip_mask = 16'h0001;
         2'h2:    slip_mask = 16'h0003;
         2'h3:    slip_mask = 16'h000F;
         default: slip_mask = 16'h0000;
      endcase
   endfunction : slip_mask

   logic [15:0] control, rf_cp, ref_div, timeout;
   logic [15:0] next_control, next_rf_cp, next_ref_div, next_timeout;
   logic [2:0]  irq_status, irq_enable, next_irq_status, next_irq_enable;
   logic [15:0] next_rdata;

   logic [15:0] rdiv_cnt, next_rdiv_cnt;
   logic [15:0] slip_cnt, next_slip_cnt;
   logic [1:0]  qcnt, next_qcnt;
   logic        next_comparison_edge;
   logic        div_edge;
   logic        ld_sample;

   pll_ctl_pkg::acq_state_t state, next_state;
   logic [15:0] tcnt, next_tcnt;
   logic        timeout_pulse;

   logic rf_locked, if_locked, rf_locked_q, if_locked_q;
   logic next_ref_oe, next_test_pin, next_fastlock, next_irq;
   logic [3:0] next_gain;

   logic [1:0] slip_sel;
   assign slip_sel = control[`CTL_SLIP_HI:`CTL_SLIP_LO];

   // register port
   always_comb begin
      next_control    = control;
      next_rf_cp      = rf_cp;
      next_ref_div    = ref_div;
      next_timeout    = timeout;
      next_irq_enable = irq_enable;
      next_irq_status = irq_status;
      next_rdata      = 16'h0000;
      if (wr) begin
         if (addr == `ADDR_CONTROL) begin
            next_control = wdata;
         end else if (addr == `ADDR_RF_CP) begin
            next_rf_cp = wdata;
         end else if (addr == `ADDR_REF_DIV) begin
            next_ref_div = wdata;
         end else if (addr == `ADDR_TIMEOUT) begin
            next_timeout = wdata;
         end else if (addr == `ADDR_IRQ_CLEAR) begin
            next_irq_status = irq_status & ~wdata[2:0];
         end else if (addr == `ADDR_IRQ_ENABLE) begin
            next_irq_enable = wdata[2:0];
         end
      end
      if (rd) begin
         if (addr == `ADDR_CONTROL) begin
            next_rdata = control;
         end else if (addr == `ADDR_RF_CP) begin
            next_rdata = rf_cp;
         end else if (addr == `ADDR_REF_DIV) begin
            next_rdata = ref_div;
         end else if (addr == `ADDR_TIMEOUT) begin
            next_rdata = timeout;
         end else if (addr == `ADDR_LOCK_STATUS) begin
            next_rdata = {11'h000, state, if_locked, rf_locked};
         end else if (addr == `ADDR_IRQ_STATUS) begin
            next_rdata = {13'h0000, irq_status};
         end else if (addr == `ADDR_IRQ_ENABLE) begin
            next_rdata = {13'h0000, irq_enable};
         end
      end
      // events: rf lock change, if lock change, acquisition timeout; set wins over clear
      next_irq_status = next_irq_status
                      | {timeout_pulse, if_locked ^ if_locked_q, rf_locked ^ rf_locked_q};
   end

   // reference divider, slip reduction and quarter-rate
   always_comb begin
      next_rdiv_cnt        = rdiv_cnt;
      next_comparison_edge = 1'b0;
      next_slip_cnt        = slip_cnt;
      next_qcnt            = qcnt;
      div_edge             = 1'b0;
      ld_sample            = 1'b0;
      if (ref_edge) begin
         if (rdiv_cnt + 16'h0001 >= ref_div) begin
            next_rdiv_cnt = 16'h0000;
            div_edge      = 1'b1;
         end else begin
            next_rdiv_cnt = rdiv_cnt + 16'h0001;
         end
      end
      if (div_edge) begin
         // while engaged, only one edge of 2, 4 or 16 reaches the phase detector
         if (state == pll_ctl_pkg::ACQ_ENGAGE && slip_sel != pll_ctl_pkg::SLIP_OFF) begin
            if ((slip_cnt & slip_mask(slip_sel)) == slip_mask(slip_sel)) begin
               next_comparison_edge = 1'b1;
               next_slip_cnt        = 16'h0000;
            end else begin
               next_slip_cnt = slip_cnt + 16'h0001;
            end
         end else begin
            next_comparison_edge = 1'b1;
            next_slip_cnt        = 16'h0000;
         end
      end
      if (next_comparison_edge) begin
         if (!control[`CTL_QUARTER]) begin
            ld_sample = 1'b1;
         end else if (qcnt == `QUARTER_DIV) begin
            ld_sample = 1'b1;
            next_qcnt = 2'h0;
         end else begin
            next_qcnt = qcnt + 2'h1;
         end
      end
   end

   // acquisition timeout: a write of the RF gain register starts acquisition when the timeout register is nonzero
   always_comb begin
      next_state    = state;
      next_tcnt     = tcnt;
      timeout_pulse = 1'b0;
      case (state)
         pll_ctl_pkg::ACQ_IDLE: begin
            next_state = pll_ctl_pkg::ACQ_STEADY;
         end
         pll_ctl_pkg::ACQ_ENGAGE: begin
            if (div_edge) begin
               if (tcnt + 16'h0001 >= timeout) begin
                  next_state    = pll_ctl_pkg::ACQ_STEADY;
                  next_tcnt     = 16'h0000;
                  timeout_pulse = 1'b1;
               end else begin
                  next_tcnt = tcnt + 16'h0001;
               end
            end
         end
         pll_ctl_pkg::ACQ_STEADY: begin
            next_tcnt = 16'h0000;
         end
         default: begin
            next_state = pll_ctl_pkg::ACQ_IDLE;
         end
      endcase
      if (wr && addr == `ADDR_RF_CP && timeout != 16'h0000) begin
         next_state = pll_ctl_pkg::ACQ_ENGAGE;
         next_tcnt  = 16'h0000;
      end
   end

   lock_detector #(.ACQ_CYCLES(RF_ACQ), .REL_CYCLES(RF_REL)) u_rf_ld (
      .sys_clk      (sys_clk),
      .rst          (rst),
      .powered_down (control[`CTL_RF_PD]),
      .sample       (ld_sample),
      .phase_err    (rf_phase_err),
      .locked       (rf_locked)
   );

   lock_detector #(.ACQ_CYCLES(IF_ACQ), .REL_CYCLES(IF_REL)) u_if_ld (
      .sys_clk      (sys_clk),
      .rst          (rst),
      .powered_down (control[`CTL_IF_PD]),
      .sample       (ld_sample),
      .phase_err    (if_phase_err),
      .locked       (if_locked)
   );

   // outputs
   always_comb begin
      next_ref_oe   = control[`CTL_REF_OE] | ref_output_force_pin;
      next_fastlock = 1'b0;
      next_gain     = rf_cp[`CP_STEADY_HI:`CP_STEADY_LO];
      if (state == pll_ctl_pkg::ACQ_ENGAGE) begin
         next_gain     = rf_cp[`CP_FAST_HI:`CP_FAST_LO];
         next_fastlock = control[`CTL_BOOST_EN];
      end
      case (pll_ctl_pkg::test_pin_selector_t'(control[`CTL_MUX_HI:`CTL_MUX_LO]))
         pll_ctl_pkg::MUX_RF_LOCK:   next_test_pin = rf_locked & ~control[`CTL_RF_PD];
         pll_ctl_pkg::MUX_IF_LOCK:   next_test_pin = if_locked & ~control[`CTL_IF_PD];
         pll_ctl_pkg::MUX_BOTH_LOCK: next_test_pin = rf_locked & if_locked;
         pll_ctl_pkg::MUX_REF_DIV:   next_test_pin = comparison_edge;
         default:                    next_test_pin = 1'b0;
      endcase
      next_irq = |(next_irq_status & irq_enable);
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         control                  <= `CONTROL_RESET;
         rf_cp                    <= `RF_CP_RESET;
         ref_div                  <= `REF_DIV_RESET;
         timeout                  <= `TIMEOUT_RESET;
         irq_status               <= 3'h0;
         irq_enable               <= 3'h0;
         rdata                    <= 16'h0000;
         rdiv_cnt                 <= 16'h0000;
         slip_cnt                 <= 16'h0000;
         qcnt                     <= 2'h0;
         comparison_edge          <= 1'b0;
         state                    <= pll_ctl_pkg::ACQ_IDLE;
         tcnt                     <= 16'h0000;
         rf_locked_q              <= 1'b0;
         if_locked_q              <= 1'b0;
         ref_buffer_output_enable <= 1'b0;
         rf_cp_gain               <= 4'h0;
         fastlock_switch          <= 1'b0;
         test_lock_output_pin     <= 1'b0;
         irq                      <= 1'b0;
      end else begin
         control                  <= next_control;
         rf_cp                    <= next_rf_cp;
         ref_div                  <= next_ref_div;
         timeout                  <= next_timeout;
         irq_status               <= next_irq_status;
         irq_enable               <= next_irq_enable;
         rdata                    <= next_rdata;
         rdiv_cnt                 <= next_rdiv_cnt;
         slip_cnt                 <= next_slip_cnt;
         qcnt                     <= next_qcnt;
         comparison_edge          <= next_comparison_edge;
         state                    <= next_state;
         tcnt                     <= next_tcnt;
         rf_locked_q              <= rf_locked;
         if_locked_q              <= if_locked;
         ref_buffer_output_enable <= next_ref_oe;
         rf_cp_gain               <= next_gain;
         fastlock_switch          <= next_fastlock;
         test_lock_output_pin     <= next_test_pin;
         irq                      <= next_irq;
      end
   end
endmodule : pll_lock_detect_control
`default_nettype wire

// [dv/pll_lock_detect_control_sva.sv]
// port assertions for the synthesizer control block
// assumes reference edges at least eight clocks apart
`timescale 1ns/100ps
`default_nettype none
module pll_lock_detect_control_sva #(
   parameter int CLK_NS = 4
) (
   input wire logic        sys_clk,
   input wire logic        rst,
   input wire logic [3:0]  addr,
   input wire logic        wr,
   input wire logic        rd,
   input wire logic [15:0] rdata,
   input wire logic        ref_edge,
   input wire logic        ref_output_force_pin,
   input wire logic        ref_buffer_output_enable,
   input wire logic        comparison_edge,
   input wire logic [3:0]  rf_cp_gain,
   input wire logic        fastlock_switch,
   input wire logic        test_lock_output_pin,
   input wire logic        irq
);
   logic [3:0] wr_hist, ref_hist, cmp_hist;
   logic [3:0] next_wr_hist, next_ref_hist, next_cmp_hist;
   logic       recent;
   always_comb begin
      next_wr_hist = rst ? 4'h0 : {wr_hist[2:0], wr};
      next_ref_hist = rst ? 4'h0 : {ref_hist[2:0], ref_edge};
      next_cmp_hist = rst ? 4'h0 : {cmp_hist[2:0], comparison_edge};
      // any cause that may move a status output in the last few cycles
      recent = (|wr_hist) || (|ref_hist) || (|cmp_hist) || comparison_edge;
   end
   always_ff @(posedge sys_clk) begin
      wr_hist <= next_wr_hist;
      ref_hist <= next_ref_hist;
      cmp_hist <= next_cmp_hist;
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   sequence s_cmp_quiet;
      !comparison_edge [*3];
   endsequence
   property p_force_enable;
      ref_output_force_pin |=> ref_buffer_output_enable;
   endproperty
   property p_cmp_from_ref;
      comparison_edge |-> |ref_hist;
   endproperty
   property p_cmp_pulse;
      comparison_edge |=> s_cmp_quiet;
   endproperty
   property p_fast_engage;
      $rose(fastlock_switch) |-> |wr_hist;
   endproperty
   property p_gain_cause;
      $changed(rf_cp_gain) |-> recent;
   endproperty
   property p_pin_cause;
      $changed(test_lock_output_pin) |-> recent;
   endproperty
   property p_rdata_idle;
      !rd |=> rdata == 16'h0000;
   endproperty
   property p_irq_cause;
      $rose(irq) |-> recent;
   endproperty
   a_force_enable: assert property (p_force_enable)
      else $error("force pin left buffer off");
   a_cmp_from_ref: assert property (p_cmp_from_ref)
      else $error("comparison edge without reference edge");
   a_cmp_pulse: assert property (p_cmp_pulse)
      else $error("comparison edges too close");
   a_fast_engage: assert property (p_fast_engage)
      else $error("fastlock engaged without a write");
   a_gain_cause: assert property (p_gain_cause)
      else $error("gain moved without cause");
   a_pin_cause: assert property (p_pin_cause)
      else $error("lock pin moved between samples");
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data not zero when idle");
   a_irq_cause: assert property (p_irq_cause)
      else $error("interrupt rose without cause");
endmodule : pll_lock_detect_control_sva
bind pll_lock_detect_control pll_lock_detect_control_sva #(.CLK_NS(CLK_NS)) u_sva (
   .sys_clk, .rst, .addr, .wr, .rd, .rdata, .ref_edge, .ref_output_force_pin,
   .ref_buffer_output_enable, .comparison_edge, .rf_cp_gain, .fastlock_switch,
   .test_lock_output_pin, .irq
);
`default_nettype wire

// [dv/ref_osc_model.sv]
// reference oscillator and phase detector: one edge per PERIOD clocks
// assumes the bench sets the error the next reference cycle shows
`timescale 1ns/100ps
`default_nettype none
module ref_osc_model #(
   parameter int PERIOD = 8
) (
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic [7:0] rf_level,
   input  wire logic [7:0] if_level,
   output logic            ref_edge,
   output logic      [7:0] rf_phase_err,
   output logic      [7:0] if_phase_err
);
   int cnt;
   always_ff @(posedge sys_clk) begin
      cnt <= (rst || cnt == PERIOD - 1) ? 0 : cnt + 1;
      ref_edge <= !rst && cnt == PERIOD - 1;
      // error is held for the whole reference cycle it belongs to
      if (rst) begin
         rf_phase_err <= 8'hff;
         if_phase_err <= 8'hff;
      end else if (cnt == PERIOD - 1) begin
         rf_phase_err <= rf_level;
         if_phase_err <= if_level;
      end
   end
endmodule : ref_osc_model
`default_nettype wire

// [dv/pll_lock_detect_control_tb.sv]
// self-checking bench for the synthesizer control block
// assumes the reference model and the checker are compiled first
`timescale 1ns/100ps
`default_nettype none
module pll_lock_detect_control_tb;
   logic        sys_clk = 1'b0;
   logic        rst = 1'b1;
   logic [3:0]  addr = 4'h0;
   logic [15:0] wdata = 16'h0000;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic        ref_output_force_pin = 1'b0;
   logic [7:0]  rf_level = 8'hff;
   logic [7:0]  if_level = 8'hff;
   logic [15:0] rdata, got;
   logic [7:0]  rf_phase_err, if_phase_err;
   logic [3:0]  rf_cp_gain;
   logic        ref_edge, ref_buffer_output_enable, comparison_edge;
   logic        fastlock_switch, test_lock_output_pin, irq;
   int          bad_count = 0;
   int          compares = 0;
   int          c;
   int          c2;
   logic [3:0]  idx [5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h9};
   logic [15:0] rv [5] = '{16'h0000, 16'h00f0, 16'h000a, 16'h0040, 16'h0000};
   always #2 sys_clk = ~sys_clk;
   ref_osc_model u_ref_osc_model (.sys_clk, .rst, .rf_level, .if_level, .ref_edge,
      .rf_phase_err, .if_phase_err);
   pll_lock_detect_control u_pll_lock_detect_control (.sys_clk, .rst, .addr, .wdata, .wr,
      .rd, .rdata, .ref_edge, .ref_output_force_pin, .rf_phase_err, .if_phase_err,
      .ref_buffer_output_enable, .comparison_edge, .rf_cp_gain, .fastlock_switch,
      .test_lock_output_pin, .irq);
   task automatic summarize;
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : summarize
   task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
      compares++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %0t %s got %h want %h", $time, m, g, e);
      end
   endtask : chk
   task automatic chk_rng(input int g, input int lo, input int hi, input string m);
      compares++;
      if (g < lo || g > hi) begin
         bad_count++;
         $display("BAD %0t %s count %0d", $time, m, g);
      end
   endtask : chk_rng
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge sys_clk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [3:0] a, output logic [15:0] v);
      @(posedge sys_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge sys_clk);
      rd <= 1'b0;
      @(posedge sys_clk);
      v = rdata;
   endtask : rd_reg
   // wait n reference edges, each carrying the given errors
   task automatic feed(input logic [7:0] r, input logic [7:0] i, input int n);
      int k;
      rf_level <= r;
      if_level <= i;
      for (int j = 0; j < n; j++) begin
         for (k = 0; k < 20; k++) begin
            @(posedge sys_clk);
            if (ref_edge === 1'b1) break;
         end
         if (k == 20) begin
            bad_count++;
            $display("BAD %0t no reference edge", $time);
            summarize();
         end
      end
   endtask : feed
   task automatic fd(input logic s, input logic [7:0] v, input int n);
      feed(s ? 8'hff : v, s ? v : 8'hff, n);
   endtask : fd
   task automatic wait_pin(input logic e);
      for (int k = 0; k < 40; k++) begin
         @(posedge sys_clk);
         if (test_lock_output_pin === e) break;
      end
      chk({15'h0, test_lock_output_pin}, {15'h0, e}, "lock pin");
      if (test_lock_output_pin !== e) summarize();
   endtask : wait_pin
   task automatic lock_seq(input logic s, input logic [7:0] ok, bad, rok, rbad);
      fd(s, ok, 4);
      fd(s, bad, 1);
      fd(s, ok, 4);
      repeat (4) @(posedge sys_clk);
      chk({15'h0, test_lock_output_pin}, 16'h0000, "early lock");
      fd(s, ok, 1);
      wait_pin(1'b1);
      fd(s, rok, 3);
      chk({15'h0, test_lock_output_pin}, 16'h0001, "kept lock");
      fd(s, rbad, 1);
      wait_pin(1'b0);
   endtask : lock_seq
   task automatic cnt_cmp(input int n);
      c = 0;
      c2 = 0;
      repeat (n * 8) begin
         @(posedge sys_clk);
         if (comparison_edge === 1'b1) c++;
         if (test_lock_output_pin === 1'b1) c2++;
      end
   endtask : cnt_cmp
   initial begin
      repeat (8) @(posedge sys_clk);
      rst <= 1'b0;
      for (int i = 0; i < 5; i++) begin
         rd_reg(idx[i], got);
         chk(got, rv[i], "reset value");
      end
      $display("test reset done");
      ref_output_force_pin <= 1'b1;
      repeat (2) @(posedge sys_clk);
      chk({15'h0, ref_buffer_output_enable}, 16'h0001, "forced");
      ref_output_force_pin <= 1'b0;
      wr_reg(4'h0, 16'h0001);
      repeat (2) @(posedge sys_clk);
      chk({15'h0, ref_buffer_output_enable}, 16'h0001, "bit on");
      wr_reg(4'h0, 16'h0000);
      repeat (2) @(posedge sys_clk);
      chk({15'h0, ref_buffer_output_enable}, 16'h0000, "off");
      $display("test buffer done");
      wr_reg(4'h2, 16'h0001);
      wr_reg(4'h7, 16'h0001);
      wr_reg(4'h0, 16'h0100);
      lock_seq(1'b0, 8'h02, 8'h03, 8'h05, 8'h06);
      chk({15'h0, irq}, 16'h0001, "irq set");
      rd_reg(4'h5, got);
      chk(got & 16'h0001, 16'h0001, "rf status");
      wr_reg(4'h6, 16'h0001);
      repeat (2) @(posedge sys_clk);
      chk({15'h0, irq}, 16'h0000, "irq cleared");
      wr_reg(4'h7, 16'h0000);
      wr_reg(4'h0, 16'h0200);
      lock_seq(1'b1, 8'h03, 8'h04, 8'h07, 8'h08);
      chk({15'h0, irq}, 16'h0000, "irq masked");
      rd_reg(4'h5, got);
      chk(got & 16'h0002, 16'h0002, "if status");
      $display("test lock done");
      wr_reg(4'h0, 16'h0300);
      feed(8'h02, 8'h03, 5);
      wait_pin(1'b1);
      feed(8'h06, 8'h03, 1);
      wait_pin(1'b0);
      feed(8'h02, 8'h03, 5);
      wr_reg(4'h0, 16'h0100);
      wait_pin(1'b1);
      wr_reg(4'h0, 16'h0104);
      wait_pin(1'b0);
      wr_reg(4'h0, 16'h0102);
      feed(8'h02, 8'h03, 12);
      chk({15'h0, test_lock_output_pin}, 16'h0000, "quarter early");
      feed(8'h02, 8'h03, 12);
      wait_pin(1'b1);
      $display("test views done");
      wr_reg(4'h0, 16'h0400);
      wr_reg(4'h2, 16'h0004);
      cnt_cmp(40);
      chk_rng(c, 9, 11, "divider");
      chk_rng(c2, 9, 11, "edge view");
      wr_reg(4'h2, 16'h0001);
      wr_reg(4'h3, 16'h00ff);
      for (int m = 1; m < 4; m++) begin
         wr_reg(4'h0, 16'(m << 4));
         wr_reg(4'h1, 16'h0083);
         repeat (2) @(posedge sys_clk);
         chk({12'h0, rf_cp_gain}, 16'h0008, "fast gain");
         cnt_cmp(32);
         chk_rng(c, (32 >> (m == 3 ? 4 : m)) - 1, (32 >> (m == 3 ? 4 : m)) + 1, "slip");
      end
      wr_reg(4'h0, 16'h0040);
      wr_reg(4'h3, 16'h0004);
      wr_reg(4'h7, 16'h0004);
      wr_reg(4'h1, 16'h0093);
      wr_reg(4'h6, 16'h0004);
      repeat (2) @(posedge sys_clk);
      chk({8'h00, rf_cp_gain, 3'h0, fastlock_switch}, 16'h0091, "boost on");
      chk({15'h0, irq}, 16'h0000, "timeout irq early");
      feed(8'h02, 8'h03, 8);
      chk({8'h00, rf_cp_gain, 3'h0, fastlock_switch}, 16'h0030, "boost off");
      chk({15'h0, irq}, 16'h0001, "timeout irq");
      wr_reg(4'h0, 16'h0010);
      cnt_cmp(32);
      chk_rng(c, 31, 33, "slip steady");
      $display("test acquisition done");
      summarize();
   end
endmodule : pll_lock_detect_control_tb
`default_nettype wire
